// File: bus_host.sv
// Purpose: Remote controller model speaking the register bus
// Assumes: One write and one read at a time
// Notes:   Released write data is inverted so stale data never looks valid
module bus_host (
   // Clock
   input wire logic        clk,
   // Write side
   output logic [7:0]      awaddr,
   output logic            awvalid,
   input wire logic        awready,
   output logic [31:0]     wdata,
   output logic            wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   output logic            bready,
   // Read side
   output logic [7:0]      araddr,
   output logic            arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   output logic            rready
);
   timeunit 1ns / 1ps;
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw;
      bit w;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      aw = 0;
      w = 0;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && awready) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      // Ready raised one cycle after both are taken, on the same edge that bvalid rises, so no response is held
      @(posedge clk);
      bready <= 1'b1;
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
endmodule : bus_host

// File: scope_cmd_monitor.sv
// Purpose: Bus timing and settings checks for the command decoder
// Assumes: Sees only top-level ports
// Notes:   Settings checks look at the first and last channel only
module scope_cmd_monitor (
   // Clock and reset
   input wire logic                     ref_clk,
   input wire logic                     nrst,
   // Register bus
   input wire logic                     s_axi_awvalid,
   input wire logic                     s_axi_awready,
   input wire logic                     s_axi_wvalid,
   input wire logic                     s_axi_wready,
   input wire logic [1:0]               s_axi_bresp,
   input wire logic                     s_axi_bvalid,
   input wire logic                     s_axi_bready,
   input wire logic                     s_axi_arvalid,
   input wire logic                     s_axi_arready,
   input wire logic [31:0]              s_axi_rdata,
   input wire logic                     s_axi_rvalid,
   input wire logic                     s_axi_rready,
   // Setting consumers
   input wire scope_cmd_pkg::settings_t settings
);
   timeunit 1ns / 1ps;
   import scope_cmd_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_write_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (s_rd_take |-> ##[1:2] s_axi_rvalid)
      else $error("read data missing");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_avg_legal: assert property (settings.avgToken <= AVG_TOKEN_MAX)
      else $error("averaging token out of set");
   a_acq_legal: assert property (settings.acqMode <= ACCUMULATING_ACQUISITION)
      else $error("acquisition mode out of set");
   a_cpl_legal: assert property (settings.coupling[0] <= CPL_GND && settings.coupling[3] <= CPL_GND)
      else $error("coupling out of set");
   a_probe_legal: assert property (settings.probe[0] <= PROBE_X100)
      else $error("probe factor out of set");
   a_grid_legal: assert property (settings.grid <= GRID_AXES)
      else $error("scale style out of set");
   a_vpos_mirror: assert property (settings.vertPos[3] == -settings.offset[3])
      else $error("position not opposite to offset");
   a_range_kept: assert property ($signed(settings.range[0]) > 0)
      else $error("range not positive");
endmodule : scope_cmd_monitor
////////////////////////////////////////////////////////////////////////////////
bind scope_setting_command_decoder scope_cmd_monitor i_mon (.ref_clk, .nrst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .settings);

// File: scope_cmd_pkg.sv
// Purpose: Shared constants and types for the scope setting command decoder
// Assumes: AXI4-Lite register access, 32-bit data, 8-bit byte addresses
// Notes:   Numeric arguments (offset, range) are signed millivolts
package scope_cmd_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_ARG    = 8'h04;
   localparam logic [7:0] ADDR_RESP   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_MASK   = 8'h10;
   localparam logic [7:0] ADDR_INFO   = 8'h14;

   // Command word fields
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_QRY_BIT = 4;
   localparam int CMD_CH_LSB  = 5;
   localparam int CMD_TOK_LSB = 8;
   localparam int CMD_WIDTH   = 12;

   typedef enum logic [3:0] {
      OP_ACQ_COUNT   = 4'h0, OP_ACQ_POINTS  = 4'h1, OP_ACQ_TYPE   = 4'h2,
      OP_CH_COUPLING = 4'h3, OP_CH_OFFSET   = 4'h4, OP_CH_PROBE   = 4'h5,
      OP_CH_RANGE    = 4'h6, OP_DISP_GRID   = 4'h7, OP_DISP_OVWR  = 4'h8,
      OP_DISP_JOIN   = 4'h9, OP_DISP_FILL   = 4'hA, OP_SYS_ERROR  = 4'hB
   } op_t;

   // Token encodings; averaging: 0 off, n selects 2**n
   localparam logic [3:0] AVG_OFF        = 4'h0;
   localparam logic [3:0] AVG_TOKEN_MAX  = 4'h8;
   localparam logic [3:0] ACQ_NORMAL     = 4'h0;
   localparam logic [3:0] DENSE_ACQUISITION        = 4'h1;
   localparam logic [3:0] ACCUMULATING_ACQUISITION = 4'h2;
   localparam logic [3:0] CPL_AC         = 4'h0;
   localparam logic [3:0] CPL_DC         = 4'h1;
   localparam logic [3:0] CPL_GND        = 4'h2;
   localparam logic [3:0] PROBE_X1       = 4'h0;
   localparam logic [3:0] PROBE_X100     = 4'h2;
   localparam logic [3:0] GRID_FULL      = 4'h0;
   localparam logic [3:0] GRID_AXES      = 4'h2;
   localparam logic [3:0] OVWR_INFINITE  = 4'h1;
   localparam logic [3:0] FILL_SINE      = 4'h1;
   localparam logic [3:0] FLAG_ON        = 4'h1;

   localparam logic [31:0] OFFSET_RESET  = 32'h0000_0000;
   localparam logic [31:0] RANGE_RESET   = 32'h0000_1F40;
   localparam logic [13:0] POINTS_MAX    = 14'h2000;
   localparam logic [15:0] ERR_CMD       = 16'hFF9C;
   localparam logic [15:0] ERR_NONE      = 16'h0000;
   localparam int          ERR_DEPTH     = 15;

   // Interrupt status bits
   localparam int ST_DONE = 0;
   localparam int ST_ERR  = 1;
   localparam int ST_OVF  = 2;
   localparam int ST_W    = 3;

   typedef enum logic [1:0] {CS_IDLE = 2'b00, CS_EXEC = 2'b01, CS_DONE = 2'b11} cmd_state_t;

   typedef struct packed {
      logic [3:0]        avgToken;
      logic [3:0]        acqMode;
      logic [3:0][3:0]   coupling;
      logic [3:0][31:0]  offset;
      logic [3:0][31:0]  vertPos;
      logic [3:0][3:0]   probe;
      logic [3:0][31:0]  range;
      logic [3:0]        grid;
      logic              overwriteMode;
      logic              dotJoin;
      logic              displayCurveFill;
   } settings_t;

endpackage : scope_cmd_pkg

// File: scope_setting_command_decoder.sv
// Purpose: Executes scope setting commands and queries written over AXI4-Lite
// Assumes: Points count comes from logic on ref_clk
// Notes:   One command at a time; answers appear in the response register
module scope_setting_command_decoder (
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   // AXI4-Lite slave
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Acquisition side
   input  wire logic [13:0]              pointsCount,
   // Setting consumers
   output scope_cmd_pkg::settings_t      settings,
   output logic                          irq
);
   import scope_cmd_pkg::*;

   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;

   logic                          awHeld, next_awHeld;
   logic [7:0]                    awAddr, next_awAddr;
   logic                          wHeld, next_wHeld;
   logic [31:0]                   wData, next_wData;
   logic [3:0]                    wStrb, next_wStrb;
   logic [1:0]                    next_bresp, next_rresp;
   logic                          next_bvalid, next_rvalid;
   logic [31:0]                   next_rdata;
   cmd_state_t                    cmdState, next_cmdState;
   logic [CMD_WIDTH-1:0]          cmdWord, next_cmdWord;
   logic [31:0]                   argReg, next_argReg;
   logic [31:0]                   respReg, next_respReg;
   logic [ST_W-1:0]               status, next_status;
   logic [ST_W-1:0]               mask, next_mask;
   settings_t                     next_settings;
   logic [ERR_DEPTH-1:0][15:0]    errQ, next_errQ;
   logic [3:0]                    errCount, next_errCount;

   // Decoded command fields
   op_t                           cmdOp;
   logic                          cmdQuery;
   logic [2:0]                    cmdCh;
   logic [1:0]                    chIdx;
   logic [3:0]                    cmdTok;
   logic                          chOk;
   logic [13:0]                   pointsClamped;

   assign cmdOp    = op_t'(cmdWord[CMD_OP_LSB +: 4]);
   assign cmdQuery = cmdWord[CMD_QRY_BIT];
   assign cmdCh    = cmdWord[CMD_CH_LSB +: 3];
   assign chIdx    = 2'(cmdCh - 3'h1);
   assign cmdTok   = cmdWord[CMD_TOK_LSB +: 4];
   assign chOk     = (cmdCh >= 3'h1) && (cmdCh <= 3'h4);
   assign pointsClamped = (pointsCount > POINTS_MAX) ? POINTS_MAX : pointsCount;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction : mergeBytes

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: bus slave, command execution, error queue, interrupts

   always_comb begin
      logic             doWrite;
      logic [7:0]       wAddrW;
      logic             cmdErr;
      logic [ST_W-1:0]  stSet;
      logic [ST_W-1:0]  stClr;
      doWrite        = 1'b0;
      wAddrW         = {awAddr[7:2], 2'b00};
      cmdErr         = 1'b0;
      stSet          = '0;
      stClr          = '0;
      next_awHeld    = awHeld;
      next_awAddr    = awAddr;
      next_wHeld     = wHeld;
      next_wData     = wData;
      next_wStrb     = wStrb;
      next_bvalid    = s_axi_bvalid;
      next_bresp     = s_axi_bresp;
      next_rvalid    = s_axi_rvalid;
      next_rresp     = s_axi_rresp;
      next_rdata     = s_axi_rdata;
      next_cmdState  = cmdState;
      next_cmdWord   = cmdWord;
      next_argReg    = argReg;
      next_respReg   = respReg;
      next_mask      = mask;
      next_settings  = settings;
      next_errQ      = errQ;
      next_errCount  = errCount;

      // Address and data taken independently, in either order
      if (s_axi_awvalid && s_axi_awready) begin
         next_awHeld = 1'b1;
         next_awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_wHeld = 1'b1;
         next_wData = s_axi_wdata;
         next_wStrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (awHeld && wHeld && !s_axi_bvalid) begin
         doWrite     = 1'b1;
         next_awHeld = 1'b0;
         next_wHeld  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = RESP_OK;
         case (wAddrW)
            ADDR_CMD: begin
               // A second command while one executes is refused
               if (cmdState == CS_IDLE && wStrb[1:0] == 2'b11) begin
                  next_cmdWord  = wData[CMD_WIDTH-1:0];
                  next_cmdState = CS_EXEC;
               end else begin
                  next_bresp = RESP_ERR;
               end
            end
            ADDR_ARG:    next_argReg = mergeBytes(argReg, wData, wStrb);
            ADDR_STATUS: stClr = wStrb[0] ? wData[ST_W-1:0] : '0;
            ADDR_MASK:   next_mask = wStrb[0] ? wData[ST_W-1:0] : mask;
            ADDR_RESP, ADDR_INFO: ;
            default:     next_bresp = RESP_ERR;
         endcase
      end

      // Read channel
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OK;
         case ({s_axi_araddr[7:2], 2'b00})
            ADDR_CMD:    next_rdata = {20'h0_0000, cmdWord};
            ADDR_ARG:    next_rdata = argReg;
            ADDR_RESP:   next_rdata = respReg;
            ADDR_STATUS: next_rdata = {29'h0000_0000, status};
            ADDR_MASK:   next_rdata = {29'h0000_0000, mask};
            ADDR_INFO:   next_rdata = {27'h000_0000, errCount, cmdState != CS_IDLE};
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = RESP_ERR;
            end
         endcase
      end

      // Command execution
      case (cmdState)
         CS_IDLE: ;
         CS_EXEC: begin
            next_cmdState = CS_DONE;
            case (cmdOp)
               OP_ACQ_COUNT: begin
                  if (cmdQuery) next_respReg = {28'h000_0000, settings.avgToken};
                  else if (cmdTok <= AVG_TOKEN_MAX) next_settings.avgToken = cmdTok;
                  else cmdErr = 1'b1;
               end
               OP_ACQ_POINTS: begin
                  if (cmdQuery) next_respReg = {18'h0_0000, pointsClamped};
                  else cmdErr = 1'b1;
               end
               OP_ACQ_TYPE: begin
                  if (cmdQuery) next_respReg = {28'h000_0000, settings.acqMode};
                  else if (cmdTok <= ACCUMULATING_ACQUISITION) next_settings.acqMode = cmdTok;
                  else cmdErr = 1'b1;
               end
               OP_CH_COUPLING, OP_CH_OFFSET, OP_CH_PROBE, OP_CH_RANGE: begin
                  if (!chOk) begin
                     cmdErr = 1'b1;
                  end else if (cmdQuery) begin
                     case (cmdOp)
                        OP_CH_COUPLING: next_respReg = {28'h000_0000, settings.coupling[chIdx]};
                        OP_CH_OFFSET:   next_respReg = settings.offset[chIdx];
                        OP_CH_PROBE:    next_respReg = {28'h000_0000, settings.probe[chIdx]};
                        default:        next_respReg = settings.range[chIdx];
                     endcase
                  end else begin
                     case (cmdOp)
                        OP_CH_COUPLING: begin
                           if (cmdTok <= CPL_GND) next_settings.coupling[chIdx] = cmdTok;
                           else cmdErr = 1'b1;
                        end
                        OP_CH_OFFSET: begin
                           next_settings.offset[chIdx]  = argReg;
                           next_settings.vertPos[chIdx] = 32'(~argReg + 32'h0000_0001);
                        end
                        OP_CH_PROBE: begin
                           if (cmdTok <= PROBE_X100) next_settings.probe[chIdx] = cmdTok;
                           else cmdErr = 1'b1;
                        end
                        default: begin
                           // A full scale must be positive
                           if (!argReg[31] && argReg != 32'h0000_0000) begin
                              next_settings.range[chIdx] = argReg;
                           end else begin
                              cmdErr = 1'b1;
                           end
                        end
                     endcase
                  end
               end
               OP_DISP_GRID: begin
                  if (cmdQuery) next_respReg = {28'h000_0000, settings.grid};
                  else if (cmdTok <= GRID_AXES) next_settings.grid = cmdTok;
                  else cmdErr = 1'b1;
               end
               OP_DISP_OVWR: begin
                  if (cmdQuery) next_respReg = {31'h0000_0000, settings.overwriteMode};
                  else if (cmdTok <= OVWR_INFINITE) next_settings.overwriteMode = cmdTok[0];
                  else cmdErr = 1'b1;
               end
               OP_DISP_JOIN: begin
                  if (cmdQuery) next_respReg = {31'h0000_0000, settings.dotJoin};
                  else if (cmdTok <= FLAG_ON) next_settings.dotJoin = cmdTok[0];
                  else cmdErr = 1'b1;
               end
               OP_DISP_FILL: begin
                  if (cmdQuery) next_respReg = {31'h0000_0000, settings.displayCurveFill};
                  else if (cmdTok <= FILL_SINE) next_settings.displayCurveFill = cmdTok[0];
                  else cmdErr = 1'b1;
               end
               OP_SYS_ERROR: begin
                  if (!cmdQuery) begin
                     cmdErr = 1'b1;
                  end else if (errCount == 4'h0) begin
                     next_respReg = {{16{ERR_NONE[15]}}, ERR_NONE};
                  end else begin
                     next_respReg = {{16{errQ[0][15]}}, errQ[0]};
                     for (int i = 0; i < ERR_DEPTH - 1; i++) begin
                        next_errQ[i] = errQ[i+1];
                     end
                     next_errQ[ERR_DEPTH-1] = ERR_NONE;
                     next_errCount = errCount - 4'h1;
                  end
               end
               default: cmdErr = 1'b1;
            endcase
            if (cmdErr) begin
               stSet[ST_ERR] = 1'b1;
               // Oldest errors kept; newest dropped once the queue is full
               if (errCount < 4'(ERR_DEPTH)) begin
                  next_errQ[errCount] = ERR_CMD;
                  next_errCount = errCount + 4'h1;
               end else begin
                  stSet[ST_OVF] = 1'b1;
               end
            end
         end
         CS_DONE: begin
            stSet[ST_DONE] = 1'b1;
            next_cmdState  = CS_IDLE;
         end
         default: next_cmdState = CS_IDLE;
      endcase

      // Set wins over a simultaneous write-one clear
      next_status = (status & ~stClr) | stSet;
      if (!doWrite) begin
         next_awHeld = next_awHeld;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         awHeld        <= 1'b0;
         awAddr        <= 8'h00;
         wHeld         <= 1'b0;
         wData         <= 32'h0000_0000;
         wStrb         <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h0000_0000;
         cmdState      <= CS_IDLE;
         cmdWord       <= '0;
         argReg        <= 32'h0000_0000;
         respReg       <= 32'h0000_0000;
         status        <= '0;
         mask          <= '0;
         irq           <= 1'b0;
         errQ          <= '0;
         errCount      <= 4'h0;
         settings.avgToken         <= AVG_OFF;
         settings.acqMode          <= ACQ_NORMAL;
         settings.coupling         <= {4{CPL_DC}};
         settings.offset           <= {4{OFFSET_RESET}};
         settings.vertPos          <= {4{OFFSET_RESET}};
         settings.probe            <= {4{PROBE_X1}};
         settings.range            <= {4{RANGE_RESET}};
         settings.grid             <= GRID_FULL;
         settings.overwriteMode    <= 1'b0;
         settings.dotJoin          <= 1'b0;
         settings.displayCurveFill <= 1'b0;
      end else begin
         awHeld        <= next_awHeld;
         awAddr        <= next_awAddr;
         wHeld         <= next_wHeld;
         wData         <= next_wData;
         wStrb         <= next_wStrb;
         // Each channel ready only while its holding slot is free
         s_axi_awready <= !next_awHeld && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !next_wHeld && !(s_axi_wvalid && s_axi_wready);
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
         s_axi_rvalid  <= next_rvalid;
         s_axi_rresp   <= next_rresp;
         s_axi_rdata   <= next_rdata;
         cmdState      <= next_cmdState;
         cmdWord       <= next_cmdWord;
         argReg        <= next_argReg;
         respReg       <= next_respReg;
         status        <= next_status;
         mask          <= next_mask;
         irq           <= |(next_status & next_mask);
         errQ          <= next_errQ;
         errCount      <= next_errCount;
         settings      <= next_settings;
      end
   end

endmodule : scope_setting_command_decoder

// File: scope_setting_command_decoder_tb.sv
// Purpose: Command and query sequences against the command decoder
// Assumes: Bus host model issues every register access
// Notes:   Each command clears status first, then polls for done
module scope_setting_command_decoder_tb;
   timeunit 1ns / 1ps;
   import scope_cmd_pkg::*;
   logic        clk;
   logic        nrst = 1'b0;
   logic [13:0] pointsCount = 14'h0000;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   settings_t   settings;
   int          n_mismatch = 0;
   int          samples_checked = 0;
   op_t         ops [8] = '{OP_ACQ_COUNT, OP_ACQ_TYPE, OP_CH_COUPLING, OP_CH_PROBE,
                            OP_DISP_GRID, OP_DISP_OVWR, OP_DISP_JOIN, OP_DISP_FILL};
   logic [3:0]  tmax [8] = '{AVG_TOKEN_MAX, ACCUMULATING_ACQUISITION, CPL_GND,
                             PROBE_X100, GRID_AXES, OVWR_INFINITE, FLAG_ON, FILL_SINE};
   ////////////////////////////////////////////////////////////////////////////
   scope_setting_command_decoder i_dut (.ref_clk(clk), .nrst(nrst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pointsCount(pointsCount),
      .settings(settings), .irq(irq));
   bus_host m (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic close_out();
      $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t response %b expected %b", $time, got, exp);
      end
   endtask : chk2
   task automatic run(input logic [3:0] op, input logic q, input logic [2:0] ch,
                      input logic [3:0] tok);
      logic [31:0] s;
      m.wr(ADDR_STATUS, 32'h0000_0007, r);
      m.wr(ADDR_CMD, {20'h00000, tok, ch, q, op}, r);
      chk2(r, 2'b00);
      s = 32'h0000_0000;
      while (s[ST_DONE] !== 1'b1) m.rd(ADDR_STATUS, s, r);
   endtask : run
   task automatic ask(input logic [3:0] op, input logic [2:0] ch, input logic [31:0] exp);
      run(op, 1'b1, ch, 4'h0);
      m.rd(ADDR_RESP, d, r);
      chk(d, exp);
   endtask : ask
   task automatic bad_popped();
      ask(OP_SYS_ERROR, 3'd1, 32'hFFFF_FF9C);
      ask(OP_SYS_ERROR, 3'd1, 32'h0000_0000);
   endtask : bad_popped
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      ask(OP_ACQ_COUNT, 3'd1, 32'h0000_0000);
      ask(OP_CH_COUPLING, 3'd4, {28'h0, CPL_DC});
      ask(OP_CH_RANGE, 3'd2, RANGE_RESET);
      foreach (ops[i]) begin
         for (int t = 0; t <= int'(tmax[i]); t++) begin
            run(ops[i], 1'b0, 3'(1 + t % 4), 4'(t));
            ask(ops[i], 3'(1 + t % 4), 32'(t));
         end
         run(ops[i], 1'b0, 3'(1 + tmax[i] % 4), tmax[i] + 4'h1);
         ask(ops[i], 3'(1 + tmax[i] % 4), {28'h0, tmax[i]});
         bad_popped();
      end
      chk({31'h0, settings.displayCurveFill}, 32'h1);
      run(OP_CH_COUPLING, 1'b0, 3'd0, CPL_AC);
      bad_popped();
      run(OP_CH_COUPLING, 1'b0, 3'd5, CPL_AC);
      bad_popped();
      m.wr(ADDR_ARG, 32'hFFFF_FC18, r);
      run(OP_CH_OFFSET, 1'b0, 3'd4, 4'h0);
      ask(OP_CH_OFFSET, 3'd4, 32'hFFFF_FC18);
      chk(settings.vertPos[3], 32'd1000);
      m.wr(ADDR_ARG, 32'h0000_1388, r);
      run(OP_CH_RANGE, 1'b0, 3'd3, 4'h0);
      m.wr(ADDR_ARG, 32'h0000_0000, r);
      run(OP_CH_RANGE, 1'b0, 3'd3, 4'h0);
      ask(OP_CH_RANGE, 3'd3, 32'h0000_1388);
      bad_popped();
      pointsCount <= 14'h1234;
      ask(OP_ACQ_POINTS, 3'd1, 32'h0000_1234);
      pointsCount <= 14'h3FFF;
      ask(OP_ACQ_POINTS, 3'd1, {18'h0, POINTS_MAX});
      run(OP_ACQ_POINTS, 1'b0, 3'd1, 4'h0);
      bad_popped();
      repeat (16) run(4'hF, 1'b0, 3'd1, 4'hF);
      repeat (14) ask(OP_SYS_ERROR, 3'd1, 32'hFFFF_FF9C);
      bad_popped();
      m.rd(8'h3C, d, r);
      chk2(r, 2'b10);
      chk(d, 32'h0000_0000);
      m.wr(ADDR_MASK, 32'h0000_0002, r);
      run(OP_DISP_JOIN, 1'b0, 3'd1, FLAG_ON);
      chk({31'h0, irq}, 32'h0);
      run(OP_DISP_JOIN, 1'b0, 3'd1, 4'h2);
      chk({31'h0, irq}, 32'h1);
      m.wr(ADDR_STATUS, 32'h0000_0002, r);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bad_popped();
      close_out();
   end
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule : scope_setting_command_decoder_tb
